// ### inc/ppb_pkg.sv
// Purpose: Shared constants and types for the parallel port block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Three ports (A, B, C) of sixteen bits each; port A may be left out.
package ppb_pkg;

  // Port numbering inside the packed vectors.
  localparam logic [1:0] PPB_PORT_A = 2'h0;
  localparam logic [1:0] PPB_PORT_B = 2'h1;
  localparam logic [1:0] PPB_PORT_C = 2'h2;

  // Register kinds within one port.
  localparam logic [1:0] PPB_KIND_DIR   = 2'h0;
  localparam logic [1:0] PPB_KIND_PIN   = 2'h1;
  localparam logic [1:0] PPB_KIND_LATCH = 2'h2;

  // Register indices as printed; the odd index forces index addressing.
  localparam logic [29:0] PPB_IDX_DIR_A   = 30'h000002c0;
  localparam logic [29:0] PPB_IDX_PIN_A   = 30'h000002c2;
  localparam logic [29:0] PPB_IDX_LATCH_A = 30'h000002c4;
  localparam logic [29:0] PPB_IDX_DIR_B   = 30'h000002c6;
  localparam logic [29:0] PPB_IDX_PIN_B   = 30'h000002c8;
  localparam logic [29:0] PPB_IDX_LATCH_B = 30'h000002cb;
  localparam logic [29:0] PPB_IDX_DIR_C   = 30'h000002cc;
  localparam logic [29:0] PPB_IDX_PIN_C   = 30'h000002ce;
  localparam logic [29:0] PPB_IDX_LATCH_C = 30'h000002d0;

  // Implemented bits per port; direction registers reset to these values, port A to zero when it is left out.
  localparam logic [15:0] PPB_MASK_A = 16'hf6c0;
  localparam logic [15:0] PPB_MASK_B = 16'hffff;
  localparam logic [15:0] PPB_MASK_C = 16'he006;

  // Reset values of latches, synchronisers and drivers.
  localparam logic [15:0] PPB_LATCH_RESET = 16'h0000;
  localparam logic [15:0] PPB_ZERO16      = 16'h0000;

  // AHB-Lite field values.
  localparam logic [1:0] PPB_HTRANS_NONSEQ = 2'h2;
  localparam logic       PPB_HRESP_OKAY    = 1'b0;

  // Three ports of sixteen bits, port A in the lowest slot.
  typedef logic [2:0][15:0] ppb_vec_t;

  // Result of decoding one bus address.
  typedef struct packed {
    logic       hit;
    logic [1:0] port;
    logic [1:0] kind;
  } ppb_decode_t;

  // Pins as seen from the pad ring.
  typedef struct packed {
    ppb_vec_t level;
  } ppb_pin_in_t;

  typedef struct packed {
    ppb_vec_t level;
    ppb_vec_t enable;
  } ppb_pin_out_t;

  // All state of the block.
  typedef struct packed {
    ppb_vec_t    dir;
    ppb_vec_t    lat;
    ppb_vec_t    sync1;
    ppb_vec_t    sync2;
    ppb_vec_t    oe;
    logic        dpValid;
    logic        dpWrite;
    logic [1:0]  dpPort;
    logic [1:0]  dpKind;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
  } ppb_state_t;

endpackage

// ### logic/ppb_port_block.sv
// Purpose: Parallel port block with direction, latch and pin-level registers on AHB-Lite.
// Assumes: Pins are asynchronous inputs; peripherals report which pins they drive.
// Notes:   Zero wait states; all outputs come from flip-flops, so driver changes lag one cycle.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module ppb_port_block
  import ppb_pkg::*;
#(
  parameter bit PORT_A_PRESENT = 1'b1
) (
  // Clock, reset and enable.
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         clkEn,
  // AHB-Lite slave.
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Peripheral ownership and analog configuration.
  input  wire ppb_vec_t     periphActive,
  input  wire ppb_vec_t     analogSel,
  // Pins.
  input  wire ppb_pin_in_t  pinIn,
  output ppb_pin_out_t      pinOut
);

  // Implemented bits; an omitted port A has none.
  // Every write, read and driver enable is masked with this vector, so a missing bit can never
  // hold direction or latch state, show up on the bus or turn on a pad driver.
  localparam ppb_vec_t IMPL = {PPB_MASK_C, PPB_MASK_B, (PORT_A_PRESENT ? PPB_MASK_A : PPB_ZERO16)};

  // Reset image of the whole state.
  // Keeping it in one constant means the reset branch assigns nothing but constants.
  // The bus answers ready and OKAY straight out of reset.
  localparam ppb_state_t RESET_STATE = '{
    dir:     IMPL,
    lat:     {3{PPB_LATCH_RESET}},
    sync1:   '0,
    sync2:   '0,
    oe:      '0,
    dpValid: 1'b0,
    dpWrite: 1'b0,
    dpPort:  2'h0,
    dpKind:  2'h0,
    rdata:   32'h00000000,
    ready:   1'b1,
    resp:    PPB_HRESP_OKAY
  };

  // Map a byte address onto port and register kind; unlisted addresses miss.
  // The upper address bits are fully decoded, so aliases of a register never hit.
  // Port A addresses miss when that port is left out of the build.
  // The decoder is shared by the write capture and the read path.
  function automatic ppb_decode_t ppbDecode(input logic [31:0] addr);
    ppb_decode_t d;
    d = '{hit: 1'b1, port: PPB_PORT_A, kind: PPB_KIND_DIR};
    if (addr[1:0] != 2'h0) begin
      d.hit = 1'b0;
    end else begin
      unique case (addr[31:2])
        PPB_IDX_DIR_A:   d = '{hit: PORT_A_PRESENT, port: PPB_PORT_A, kind: PPB_KIND_DIR};
        PPB_IDX_PIN_A:   d = '{hit: PORT_A_PRESENT, port: PPB_PORT_A, kind: PPB_KIND_PIN};
        PPB_IDX_LATCH_A: d = '{hit: PORT_A_PRESENT, port: PPB_PORT_A, kind: PPB_KIND_LATCH};
        PPB_IDX_DIR_B:   d = '{hit: 1'b1, port: PPB_PORT_B, kind: PPB_KIND_DIR};
        PPB_IDX_PIN_B:   d = '{hit: 1'b1, port: PPB_PORT_B, kind: PPB_KIND_PIN};
        PPB_IDX_LATCH_B: d = '{hit: 1'b1, port: PPB_PORT_B, kind: PPB_KIND_LATCH};
        PPB_IDX_DIR_C:   d = '{hit: 1'b1, port: PPB_PORT_C, kind: PPB_KIND_DIR};
        PPB_IDX_PIN_C:   d = '{hit: 1'b1, port: PPB_PORT_C, kind: PPB_KIND_PIN};
        PPB_IDX_LATCH_C: d = '{hit: 1'b1, port: PPB_PORT_C, kind: PPB_KIND_LATCH};
        default:         d.hit = 1'b0;
      endcase
    end
    return d;
  endfunction

  // State, its next value and the address-phase decode.
  ppb_state_t  st;
  ppb_state_t  next_st;
  ppb_decode_t addrDec;
  logic        accept;
  logic        dpWr;

  // An address phase is taken only when the bus says the previous one finished.
  assign addrDec = ppbDecode(haddr);
  assign accept  = hsel && (htrans == PPB_HTRANS_NONSEQ || htrans == 2'h3) && hready;
  assign dpWr    = st.dpValid && st.dpWrite;

  // Next-state logic: synchroniser, data-phase write, address-phase read, drivers.
  // Bus timing is zero wait states throughout.
  // A write is taken at the address-phase edge and lands at the data-phase edge, where hwdata stands.
  // A read is answered at the address-phase edge, so hrdata stands for the whole data phase.
  // Read data stays put until the next accepted read, which keeps a slow master safe.
  // The pad driver enable is worked out from the post-write direction, so a direction
  // write reaches the pads at the same edge at which it lands.
  // A peripheral taking a pin over is seen one edge late, since every output is a flop.
  always_comb begin
    next_st = st;
    next_st.sync1 = pinIn.level;
    next_st.sync2 = st.sync1;
    next_st.ready = 1'b1;
    next_st.resp  = PPB_HRESP_OKAY;
    // Writes land in the data phase; a pin-level write is steered into the latch.
    // Steering it there means software can never push a level onto a pad that
    // is still an input, the pad only follows once the direction bit is cleared.
    if (dpWr) begin
      unique case (st.dpKind)
        PPB_KIND_DIR:   next_st.dir[st.dpPort] = hwdata[15:0] & IMPL[st.dpPort];
        PPB_KIND_PIN:   next_st.lat[st.dpPort] = hwdata[15:0] & IMPL[st.dpPort];
        PPB_KIND_LATCH: next_st.lat[st.dpPort] = hwdata[15:0] & IMPL[st.dpPort];
        default:        next_st.lat = st.lat;
      endcase
    end
    // Capture the address phase; misses become a harmless OKAY with zero data.
    // The size field is not looked at, every access is treated as a full word.
    // A miss never sets the data-phase valid flag, so it cannot write anything.
    next_st.dpValid = accept && addrDec.hit;
    next_st.dpWrite = hwrite;
    next_st.dpPort  = addrDec.port;
    next_st.dpKind  = addrDec.kind;
    // Read data is taken from the post-write image so a back-to-back read sees the write.
    // The pin-level path uses the synchroniser output, never the raw pads, which costs
    // two cycles of latency but keeps a changing pad from reaching the bus.
    if (accept && !hwrite) begin
      next_st.rdata = 32'h00000000;
      if (addrDec.hit) begin
        unique case (addrDec.kind)
          PPB_KIND_DIR:   next_st.rdata[15:0] = next_st.dir[addrDec.port] & IMPL[addrDec.port];
          PPB_KIND_PIN:   next_st.rdata[15:0] = st.sync2[addrDec.port] & IMPL[addrDec.port]
                                                & ~analogSel[addrDec.port];
          PPB_KIND_LATCH: next_st.rdata[15:0] = next_st.lat[addrDec.port] & IMPL[addrDec.port];
          default:        next_st.rdata = 32'h00000000;
        endcase
      end
    end
    // Input-only functions never raise periphActive, so such pins behave as plain port pins.
    // A peripheral that is enabled but idle leaves its bit low, which hands the pin back
    // to the direction and latch bits.
    next_st.oe = ~next_st.dir & IMPL & ~periphActive;
  end

  // Single state register; the enable freezes everything, including the synchroniser.
  // Reset wins over the enable, so a gated clock still comes up with every pin an input.
  // A transfer presented while the enable is low is not taken and is lost; the master
  // must keep the enable high around bus traffic.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= RESET_STATE;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops.
  // Masking a flop with a constant adds no logic level, so these stay glitch free.
  // The pad level is masked so unimplemented bits never toggle.
  assign hreadyout     = st.ready;
  assign hresp         = st.resp;
  assign hrdata        = st.rdata;
  assign pinOut.level  = st.lat & IMPL;
  assign pinOut.enable = st.oe;

  // Checks run on the system clock and pause during reset.
  // They cover the bus answer, the write steering, the read masking, the pad drivers
  // and the synchroniser.
  // Properties that look across an edge, other than the reset and freeze checks, require the enable high in their antecedent,
  // because a frozen edge must leave every register as it was.
  // Reset checks turn the default disable off so they can watch the reset edge itself.
  // Nothing here looks at the testbench's own signals except as an antecedent.
  // Per-port checks sit in a generate loop near the end.
  // A failing check reports once per cycle in which it fails.
  default clocking cbSys @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // A pin a peripheral drives never carries the port driver.
  property p_periphBlocks;
    clkEn |=> (pinOut.enable & $past(periphActive)) == '0;
  endproperty
  a_periphBlocks: assert property (p_periphBlocks) else $error("Port driver on while peripheral drives pin.");

  // Without the peripheral the driver follows direction alone.
  property p_portDrives;
    clkEn |=> pinOut.enable == (~st.dir & IMPL & ~$past(periphActive));
  endproperty
  a_portDrives: assert property (p_portDrives) else $error("Port driver does not follow direction.");

  // An input pin never has its driver on.
  property p_inputNoDrive;
    (pinOut.enable & st.dir) == '0;
  endproperty
  a_inputNoDrive: assert property (p_inputNoDrive) else $error("Driver enabled on an input pin.");

  // Reset leaves every implemented pin an input and latches cleared.
  property p_resetState;
    sys_rst |=> st.dir == IMPL && st.lat == '0 && pinOut.enable == '0;
  endproperty
  a_resetState: assert property (disable iff (1'b0) p_resetState) else $error("Reset state wrong.");

  // A latch read returns the latch as it stands after the read was taken.
  property p_latchRead;
    (clkEn && accept && !hwrite && addrDec.hit && addrDec.kind == PPB_KIND_LATCH)
      |=> hrdata == {16'h0000, st.lat[st.dpPort]};
  endproperty
  a_latchRead: assert property (p_latchRead) else $error("Latch read mismatch.");

  // A latch or pin-level write stores the masked data into the latch.
  property p_latchWrite;
    (clkEn && dpWr && st.dpKind != PPB_KIND_DIR)
      |=> st.lat[$past(st.dpPort)] == ($past(hwdata[15:0]) & IMPL[$past(st.dpPort)]);
  endproperty
  a_latchWrite: assert property (p_latchWrite) else $error("Latch not updated by write.");

  // A pin-level read shows synchronised pins, masked and with analog pins low.
  property p_pinRead;
    (clkEn && accept && !hwrite && addrDec.hit && addrDec.kind == PPB_KIND_PIN)
      |=> hrdata[15:0] == ($past(st.sync2[addrDec.port]) & IMPL[$past(addrDec.port)]
                           & ~$past(analogSel[addrDec.port]));
  endproperty
  a_pinRead: assert property (p_pinRead) else $error("Pin-level read mismatch.");

  // Unimplemented bits and upper halfword always read zero.
  property p_unimplZero;
    hrdata[31:16] == 16'h0000 && (st.dir & ~IMPL) == '0 && (st.lat & ~IMPL) == '0;
  endproperty
  a_unimplZero: assert property (p_unimplZero) else $error("Unimplemented bits not zero.");

  // Pins reach the second stage two enabled cycles later.
  property p_syncDelay;
    clkEn ##1 clkEn |=> st.sync2 == $past(pinIn.level, 2);
  endproperty
  a_syncDelay: assert property (p_syncDelay) else $error("Synchroniser delay wrong.");

  // The first synchroniser stage copies the pads on every enabled edge.
  property p_syncFirst;
    clkEn |=> st.sync1 == $past(pinIn.level);
  endproperty
  a_syncFirst: assert property (p_syncFirst) else $error("First synchroniser stage wrong.");

  // The second stage reads only the first stage, never the pads.
  property p_sync2Follows;
    clkEn |=> st.sync2 == $past(st.sync1);
  endproperty
  a_sync2Follows: assert property (p_sync2Follows) else $error("Second synchroniser stage wrong.");

  // A low enable freezes every state bit, bus capture and synchroniser included.
  // Software relies on this to hold the pads steady while the clock is gated.
  property p_freeze;
    !clkEn |=> $stable(st);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while the enable was low.");

  // A direction write stores the masked data, so unimplemented bits stay clear.
  property p_dirWrite;
    (clkEn && dpWr && st.dpKind == PPB_KIND_DIR)
      |=> st.dir[$past(st.dpPort)] == ($past(hwdata[15:0]) & IMPL[$past(st.dpPort)]);
  endproperty
  a_dirWrite: assert property (p_dirWrite) else $error("Direction not updated by write.");

  // A direction write leaves every latch untouched.
  property p_dirKeepsLatch;
    (clkEn && dpWr && st.dpKind == PPB_KIND_DIR) |=> st.lat == $past(st.lat);
  endproperty
  a_dirKeepsLatch: assert property (p_dirKeepsLatch) else $error("Direction write changed a latch.");

  // A latch or pin-level write leaves every direction bit untouched.
  property p_latchKeepsDir;
    (clkEn && dpWr && st.dpKind != PPB_KIND_DIR) |=> st.dir == $past(st.dir);
  endproperty
  a_latchKeepsDir: assert property (p_latchKeepsDir) else $error("Latch write changed a direction.");

  // Without a landing write, latches and directions hold their values.
  property p_idleKeeps;
    (clkEn && !dpWr) |=> st.lat == $past(st.lat) && st.dir == $past(st.dir);
  endproperty
  a_idleKeeps: assert property (p_idleKeeps) else $error("Register changed without a write.");

  // Unmapped, misaligned and omitted-port reads answer with zero data.
  property p_missReadZero;
    (clkEn && accept && !hwrite && !addrDec.hit) |=> hrdata == 32'h00000000;
  endproperty
  a_missReadZero: assert property (p_missReadZero) else $error("Unmapped read returned data.");

  // A direction read returns the stored direction bits.
  property p_dirRead;
    (clkEn && accept && !hwrite && addrDec.hit && addrDec.kind == PPB_KIND_DIR)
      |=> hrdata == {16'h0000, st.dir[st.dpPort]};
  endproperty
  a_dirRead: assert property (p_dirRead) else $error("Direction read mismatch.");

  // Analog-configured pins read low whatever the pad level is.
  property p_analogLow;
    (clkEn && accept && !hwrite && addrDec.hit && addrDec.kind == PPB_KIND_PIN)
      |=> (hrdata[15:0] & $past(analogSel[addrDec.port])) == 16'h0000;
  endproperty
  a_analogLow: assert property (p_analogLow) else $error("Analog pin read high.");

  // Read data stands until the next accepted read; writes and idle cycles leave it alone.
  property p_rdataHold;
    (clkEn && !(accept && !hwrite)) |=> $stable(hrdata);
  endproperty
  a_rdataHold: assert property (p_rdataHold) else $error("Read data changed without a read.");

  // A hit in the address phase is carried into the data phase with its port and kind.
  property p_dpCapture;
    (clkEn && accept && addrDec.hit)
      |=> st.dpValid && st.dpPort == $past(addrDec.port) && st.dpKind == $past(addrDec.kind);
  endproperty
  a_dpCapture: assert property (p_dpCapture) else $error("Address phase not captured.");

  // Anything but an accepted hit leaves the data phase empty, so nothing is written.
  property p_noAccept;
    (clkEn && !(accept && addrDec.hit)) |=> !st.dpValid;
  endproperty
  a_noAccept: assert property (p_noAccept) else $error("Data phase opened without a hit.");

  // No port driver ever turns on for a bit that this build does not implement.
  property p_enableImpl;
    (pinOut.enable & ~IMPL) == '0;
  endproperty
  a_enableImpl: assert property (p_enableImpl) else $error("Driver enabled on an unimplemented bit.");

  // The slave never stretches a transfer and never reports an error.
  property p_zeroWait;
    hreadyout && hresp == PPB_HRESP_OKAY;
  endproperty
  a_zeroWait: assert property (p_zeroWait) else $error("Bus answer not ready or not OKAY.");

  // Reset clears read data, pad levels and the synchroniser, and leaves the bus ready.
  property p_resetOutputs;
    sys_rst |=> hrdata == 32'h00000000 && hreadyout && pinOut.level == '0 && st.sync2 == '0;
  endproperty
  a_resetOutputs: assert property (disable iff (1'b0) p_resetOutputs) else $error("Reset outputs wrong.");

  // An omitted port A keeps its direction, latch and driver enable at zero for good.
  if (!PORT_A_PRESENT) begin : gen_noPortA
    property p_portAGone;
      st.dir[PPB_PORT_A] == 16'h0000 && st.lat[PPB_PORT_A] == 16'h0000 && pinOut.enable[PPB_PORT_A] == 16'h0000;
    endproperty
    a_portAGone: assert property (p_portAGone) else $error("Omitted port shows state.");
  end

  // Per-port check that a latch or pin-level write reaches the pads one edge later.
  // Checking the pad side catches a write steered into the wrong port slot.
  for (genvar g = 0; g < 3; g++) begin : gen_padChk
    property p_latchToPad;
      (clkEn && dpWr && st.dpPort == g && st.dpKind != PPB_KIND_DIR)
        |=> pinOut.level[g] == ($past(hwdata[15:0]) & IMPL[g]);
    endproperty
    a_latchToPad: assert property (p_latchToPad) else $error("Pad level misses the latch write.");
  end

endmodule

// ### sim/parallel_io_port_block_test.sv
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Zero wait-state slave; a second instance is built without port A.
// Notes:   Only mismatches and the verdict are printed.
`timescale 1ns/1ps
module parallel_io_port_block_test;
  import ppb_pkg::*;
  logic         clk_sys = 1'b0;
  logic         sys_rst = 1'b1;
  logic         clkEn = 1'b1;
  logic         hsel = 1'b0;
  logic         hwrite = 1'b0;
  logic [1:0]   htrans = 2'h0;
  logic [31:0]  haddr = 32'h0;
  logic [31:0]  hwdata = 32'h0;
  logic         hreadyout;
  logic [31:0]  hrdata;
  logic [31:0]  hrdataNoA;
  logic [31:0]  rdNoA;
  ppb_vec_t     periphActive = '0;
  ppb_vec_t     analogSel = '0;
  ppb_vec_t     extLevel = '0;
  ppb_pin_in_t  pinIn;
  ppb_pin_out_t pinOut;
  int           errCount = 0;
  int           checked = 0;

  // The full block and a build without port A share the same bus and pins.
  ppb_port_block #(.PORT_A_PRESENT(1'b1)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .periphActive(periphActive),
    .analogSel(analogSel), .pinIn(pinIn), .pinOut(pinOut));
  ppb_port_block #(.PORT_A_PRESENT(1'b0)) u_dut_noa (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdataNoA), .periphActive(periphActive),
    .analogSel(analogSel), .pinIn(pinIn), .pinOut());
  ppb_board_model u_board (.pinOut(pinOut), .extLevel(extLevel), .pinIn(pinIn));

  // A 25 ns period clock.
  always #12.5 clk_sys = ~clk_sys;

  task automatic conclude;
    if (errCount == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; entered just after a rising edge.
  task automatic xfer(input logic wr, input logic [29:0] idx, input logic [15:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= PPB_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {idx, 2'b00};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    rdNoA = hrdataNoA;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [15:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [29:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 16'h0, r);
    chk(r, exp);
  endtask

  task automatic t_reset;
    logic [29:0] idx [10] = '{PPB_IDX_DIR_A, PPB_IDX_PIN_A, PPB_IDX_LATCH_A, PPB_IDX_DIR_B, PPB_IDX_PIN_B,
      PPB_IDX_LATCH_B, PPB_IDX_DIR_C, PPB_IDX_PIN_C, PPB_IDX_LATCH_C, 30'h2ca};
    logic [15:0] exp [10] = '{16'hf6c0, 16'h0, 16'h0, 16'hffff, 16'h0, 16'h0, 16'he006, 16'h0, 16'h0, 16'h0};
    chk({31'h0, |pinOut.enable}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      rd_chk(idx[i], {16'h0, exp[i]});
    end
    rd_chk(PPB_IDX_DIR_A, 32'hf6c0);
    chk(rdNoA, 32'h0);
  endtask

  task automatic t_sync;
    extLevel[2] <= 16'he006;
    rd_chk(PPB_IDX_PIN_C, 32'h0);
    rd_chk(PPB_IDX_PIN_C, 32'he006);
  endtask

  task automatic t_regs;
    extLevel[1] <= 16'h5a5a;
    wr(PPB_IDX_LATCH_B, 16'ha5a5);
    rd_chk(PPB_IDX_LATCH_B, 32'ha5a5);
    wr(PPB_IDX_PIN_B, 16'h1234);
    rd_chk(PPB_IDX_LATCH_B, 32'h1234);
    rd_chk(PPB_IDX_PIN_B, 32'h5a5a);
    wr(PPB_IDX_DIR_C, 16'hffff);
    rd_chk(PPB_IDX_DIR_C, 32'he006);
    wr(PPB_IDX_LATCH_C, 16'hffff);
    rd_chk(PPB_IDX_LATCH_C, 32'he006);
  endtask

  task automatic t_drive;
    wr(PPB_IDX_DIR_B, 16'h0);
    repeat (4) @(posedge clk_sys);
    chk({pinOut.enable[1], pinOut.level[1]}, 32'hffff1234);
    rd_chk(PPB_IDX_PIN_B, 32'h1234);
    periphActive[1] <= 16'h00ff;
    extLevel[1] <= 16'h00aa;
    repeat (4) @(posedge clk_sys);
    chk({16'h0, pinOut.enable[1]}, 32'hff00);
    rd_chk(PPB_IDX_PIN_B, 32'h12aa);
    periphActive[1] <= 16'h0;
    repeat (2) @(posedge clk_sys);
    chk({16'h0, pinOut.enable[1]}, 32'hffff);
  endtask

  task automatic t_analog;
    wr(PPB_IDX_DIR_B, 16'hffff);
    extLevel[1] <= 16'hffff;
    analogSel[1] <= 16'h000f;
    repeat (4) @(posedge clk_sys);
    rd_chk(PPB_IDX_PIN_B, 32'hfff0);
  endtask

  // A write presented while the enable is low must be lost; the latch keeps its value.
  task automatic t_freeze;
    clkEn <= 1'b0;
    wr(PPB_IDX_LATCH_B, 16'h3c3c);
    repeat (2) @(posedge clk_sys);
    clkEn <= 1'b1;
    rd_chk(PPB_IDX_LATCH_B, 32'h1234);
  endtask

  // Main sequence: three cycles of reset, then the scenarios.
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_sync();
    t_regs();
    t_drive();
    t_analog();
    t_freeze();
    conclude();
  end

  // Watchdog: the scenarios need well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk_sys);
    errCount++;
    conclude();
  end
endmodule

// ### sim/ppb_board_model.sv
// Purpose: Board-side model of the signals sitting on the port pins.
// Assumes: The board always drives every pad; a peripheral output shows up as the board level.
// Notes:   The port wins a pad only while its driver is enabled.
`timescale 1ns/1ps
module ppb_board_model
  import ppb_pkg::*;
(
  // Port side.
  input  wire ppb_pin_out_t pinOut,
  // Board side.
  input  wire ppb_vec_t     extLevel,
  output ppb_pin_in_t       pinIn
);
  // Resolve each pad from the port driver and the board level.
  assign pinIn.level = (pinOut.enable & pinOut.level) | (~pinOut.enable & extLevel);
endmodule
